//--- gated_prescaled_timer16.sv
// Gated prescaled 16-bit timer/counter with an AHB-Lite register slave.
`include "timer16_params.svh"

module gated_prescaled_timer16 (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic external_count_input,
  input wire logic idle_mode,
  output logic irq
);
  import timer16_pkg::*;

  // Last prescaler count before a tick, per prescale_select code.
  function automatic logic [7:0] presc_last(input logic [1:0] sel);
    case (sel)
      2'b11: presc_last = `PSC_LAST_DIV256;
      2'b10: presc_last = `PSC_LAST_DIV64;
      2'b01: presc_last = `PSC_LAST_DIV8;
      default: presc_last = `PSC_LAST_DIV1;
    endcase
  endfunction : presc_last

  function automatic logic [31:0] ctrl_word(input ctrl_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[`BIT_RUN_CONTROL] = c.run_control;
    w[`BIT_IDLE_HALT] = c.idle_halt;
    w[`BIT_GATE_ACCUMULATE_ENABLE] = c.gate_accumulate_enable;
    w[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO] = c.prescale_select;
    w[`BIT_EXT_CLOCK_SYNC] = c.ext_clock_sync;
    w[`BIT_CLOCK_SOURCE_SELECT] = c.clock_source_select;
    ctrl_word = w;
  endfunction : ctrl_word

  state_t q;
  state_t next_q;

  logic accept;
  logic src_in;
  logic src_rise;
  logic run_ok;
  logic gated;
  logic base;
  logic presc_hit;
  logic tick;
  logic gate_fall;
  logic wr_ctrl;
  logic wr_count;
  logic [1:0] st_set;
  logic [1:0] st_clr;

  always_comb begin
    next_q = q;
    accept = hsel && htrans[1] && hready;
    wr_ctrl = q.wr_pend && (q.addr == `OFS_TIMER_CONTROL);
    wr_count = q.wr_pend && (q.addr == `OFS_COUNT);

    // Sync path: the first stage feeds only the second.
    next_q.sync1 = external_count_input;
    next_q.sync2 = q.sync1;
    src_in = q.ctrl.ext_clock_sync ? q.sync2 : external_count_input;
    src_rise = src_in && !q.src_prev;
    next_q.src_prev = src_in;
    next_q.gate_prev = external_count_input;

    run_ok = q.ctrl.run_control && !(q.ctrl.idle_halt && idle_mode);
    gated = !q.ctrl.clock_source_select && q.ctrl.gate_accumulate_enable;
    if (q.ctrl.clock_source_select) begin
      base = src_rise;
    end else if (gated) begin
      base = external_count_input;
    end else begin
      base = 1'b1;
    end
    presc_hit = (q.presc == presc_last(q.ctrl.prescale_select));
    tick = run_ok && base && presc_hit;
    gate_fall = run_ok && gated && q.gate_prev && !external_count_input;

    if (run_ok && base) begin
      next_q.presc = presc_hit ? 8'h00 : q.presc + 8'h01;
    end
    // A prescaler stopped by run_control rests at zero, so a count left over from a coarser ratio
    // cannot delay the first tick of the next run by up to 255 cycles.
    if (!q.ctrl.run_control) begin
      next_q.presc = 8'h00;
    end

    st_set = 2'b00;
    if (tick) begin
      if (q.count == q.period_value) begin
        next_q.count = `COUNT_RESET;
        st_set[`ST_MATCH] = 1'b1;
      end else begin
        next_q.count = q.count + 16'h0001;
      end
    end
    st_set[`ST_GATE_FALL] = gate_fall;

    // Bus writes take effect in the data phase.
    st_clr = 2'b00;
    if (q.wr_pend) begin
      case (q.addr)
        `OFS_TIMER_CONTROL: begin
          next_q.ctrl.run_control = hwdata[`BIT_RUN_CONTROL];
          next_q.ctrl.idle_halt = hwdata[`BIT_IDLE_HALT];
          next_q.ctrl.gate_accumulate_enable = hwdata[`BIT_GATE_ACCUMULATE_ENABLE];
          next_q.ctrl.prescale_select = hwdata[`BIT_PRESCALE_HI:`BIT_PRESCALE_LO];
          next_q.ctrl.ext_clock_sync = hwdata[`BIT_EXT_CLOCK_SYNC];
          next_q.ctrl.clock_source_select = hwdata[`BIT_CLOCK_SOURCE_SELECT];
          if (q.ctrl.run_control) begin
            next_q.presc = 8'h00;
          end
        end
        `OFS_COUNT: next_q.count = hwdata[15:0];
        `OFS_PERIOD_VALUE: next_q.period_value = hwdata[15:0];
        `OFS_IRQ_STATUS: st_clr = hwdata[`ST_WIDTH-1:0];
        `OFS_IRQ_MASK: next_q.irq_mask = hwdata[`ST_WIDTH-1:0];
        default: next_q.irq_mask = q.irq_mask;
      endcase
    end
    // A new event wins over a clear in the same cycle.
    next_q.irq_status = (q.irq_status & ~st_clr) | st_set;
    next_q.irq = |(next_q.irq_status & next_q.irq_mask);

    // Reads take one wait state so the data reflects any write just finished.
    next_q.wr_pend = accept && hwrite;
    next_q.rd_pend = accept && !hwrite;
    if (accept) begin
      next_q.addr = haddr[7:0];
    end
    next_q.hreadyout = !(accept && !hwrite);
    if (q.rd_pend) begin
      case (q.addr)
        `OFS_TIMER_CONTROL: next_q.hrdata = ctrl_word(q.ctrl);
        `OFS_COUNT: next_q.hrdata = {16'h0000, q.count};
        `OFS_PERIOD_VALUE: next_q.hrdata = {16'h0000, q.period_value};
        `OFS_IRQ_STATUS: next_q.hrdata = {30'h00000000, q.irq_status};
        `OFS_IRQ_MASK: next_q.hrdata = {30'h00000000, q.irq_mask};
        default: next_q.hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
      q.period_value <= `PERIOD_RESET;
      q.hreadyout <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign hreadyout = q.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign irq = q.irq;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_stopped_holds: assert property (
    !q.ctrl.run_control && !wr_count |=> q.count == $past(q.count))
    else $error("Counter moved while stopped.");

  a_match_wraps: assert property (
    tick && !wr_count && q.count == q.period_value
      |=> q.count == 16'h0000 && q.irq_status[`ST_MATCH])
    else $error("Period match did not wrap and flag.");

  a_count_step: assert property (
    tick && !wr_count && q.count != q.period_value
      |=> q.count == $past(q.count) + 16'h0001)
    else $error("Counter did not step by one on a tick.");

  a_prescale_tick: assert property (
    tick |-> q.presc == presc_last(q.ctrl.prescale_select))
    else $error("Tick came before the prescale count ended.");

  a_div8_spacing: assert property (
    !q.ctrl.clock_source_select && !q.ctrl.gate_accumulate_enable && !idle_mode
      && q.ctrl.run_control && q.ctrl.prescale_select == 2'b01 && !q.wr_pend
      && q.presc == 8'h00 ##1 !q.wr_pend [*7] |-> tick)
    else $error("Divide by eight did not tick on the eighth cycle.");

  a_idle_halts: assert property (
    q.ctrl.idle_halt && idle_mode && !q.wr_pend |-> !tick ##1 q.presc == $past(q.presc))
    else $error("Counting continued in idle with halt set.");

  a_gate_blocks: assert property (
    gated && !external_count_input |-> !tick)
    else $error("Gated timer counted with the gate low.");

  a_ext_edge: assert property (
    q.ctrl.clock_source_select && tick |-> src_rise)
    else $error("External mode ticked without a rising edge.");

  a_sync_path: assert property (
    q.ctrl.clock_source_select && q.ctrl.ext_clock_sync && src_rise
      |-> $past(external_count_input, 2) && !$past(external_count_input, 3))
    else $error("Synchronised edge not two cycles behind the pin.");

  a_gate_flag: assert property (
    gate_fall |=> q.irq_status[`ST_GATE_FALL])
    else $error("Gate falling edge did not set its flag.");

  a_presc_clear: assert property (
    wr_ctrl && q.ctrl.run_control |=> q.presc == 8'h00)
    else $error("Control write while running kept the prescaler.");

  a_reserved_zero: assert property (
    q.rd_pend && q.addr == `OFS_TIMER_CONTROL |=> (q.hrdata & ~`CTRL_IMPL_MASK) == 32'h0)
    else $error("Unimplemented control bits read nonzero.");

  a_reset_clear: assert property (
    $fell(reset) |-> q.ctrl == '0 && q.count == 16'h0000)
    else $error("Control not clear after reset.");

  // Bus timing: reads always take one wait state, writes none.
  a_read_wait: assert property (
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read did not take exactly one wait state.");

  a_write_nowait: assert property (
    accept && hwrite |=> hreadyout)
    else $error("Write inserted a wait state.");

  a_resp_okay: assert property (
    hresp == 1'b0)
    else $error("Slave answered with an error response.");

  a_count_write: assert property (
    wr_count |=> q.count == $past(hwdata[15:0]))
    else $error("Counter write did not land.");

  a_run_write: assert property (
    wr_ctrl |=> q.ctrl.run_control == $past(hwdata[`BIT_RUN_CONTROL]))
    else $error("Run control did not follow the write.");

  a_mask_write: assert property (
    q.wr_pend && q.addr == `OFS_IRQ_MASK |=> q.irq_mask == $past(hwdata[1:0]))
    else $error("Mask write did not land.");

  a_count_read: assert property (
    q.rd_pend && q.addr == `OFS_COUNT |=> hrdata == {16'h0000, $past(q.count)})
    else $error("Counter read returned a wrong value.");

  // The interrupt line follows the sticky status through the mask.
  a_irq_level: assert property (
    irq == |(q.irq_status & q.irq_mask))
    else $error("Interrupt line disagrees with status and mask.");

  a_match_sticky: assert property (
    q.irq_status[`ST_MATCH] && !(q.wr_pend && q.addr == `OFS_IRQ_STATUS)
      |=> q.irq_status[`ST_MATCH])
    else $error("Match flag dropped without a clear.");

  a_set_wins: assert property (
    st_set[`ST_MATCH] && st_clr[`ST_MATCH] |=> q.irq_status[`ST_MATCH])
    else $error("Clear beat a same-cycle match event.");

  a_ext_no_gate: assert property (
    q.ctrl.clock_source_select |-> !gate_fall)
    else $error("Gate event raised with the external clock.");

  a_int_plain: assert property (
    !q.ctrl.clock_source_select && !gated && run_ok |-> tick == presc_hit)
    else $error("Internal clock did not tick on the prescale end.");

  a_div1_every: assert property (
    !q.ctrl.clock_source_select && !gated && run_ok && q.ctrl.prescale_select == 2'b00
      |-> tick)
    else $error("Undivided internal clock missed a cycle.");

  a_raw_edge: assert property (
    q.ctrl.clock_source_select && !q.ctrl.ext_clock_sync && src_rise
      |-> external_count_input && !$past(external_count_input))
    else $error("Unsynchronised edge not taken from the pin.");

  a_stopped_presc: assert property (
    !q.ctrl.run_control |=> q.presc == 8'h00)
    else $error("Prescaler moved while stopped.");

  a_reset_outputs: assert property (
    $fell(reset) |-> hreadyout && !irq && hrdata == 32'h00000000)
    else $error("Bus outputs not at rest after reset.");

  c_idle_hold: cover property (q.ctrl.idle_halt && idle_mode && q.ctrl.run_control);
  c_period_match: cover property (tick && q.count == q.period_value);
  c_gate_fall: cover property (gate_fall);
  c_ext_tick: cover property (q.ctrl.clock_source_select && tick);
  c_irq_rise: cover property ($rose(q.irq));

endmodule : gated_prescaled_timer16

//--- timer16_params.svh
// Register offsets, field positions, reset values and prescale counts of the timer.
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

`define OFS_TIMER_CONTROL 8'h00
`define OFS_COUNT 8'h04
`define OFS_PERIOD_VALUE 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10

`define BIT_RUN_CONTROL 15
`define BIT_IDLE_HALT 13
`define BIT_GATE_ACCUMULATE_ENABLE 6
`define BIT_PRESCALE_HI 5
`define BIT_PRESCALE_LO 4
`define BIT_EXT_CLOCK_SYNC 2
`define BIT_CLOCK_SOURCE_SELECT 1
`define CTRL_IMPL_MASK 32'h0000A076

`define ST_MATCH 0
`define ST_GATE_FALL 1
`define ST_WIDTH 2

`define PERIOD_RESET 16'hFFFF
`define COUNT_RESET 16'h0000

`define PSC_LAST_DIV1 8'h00
`define PSC_LAST_DIV8 8'h07
`define PSC_LAST_DIV64 8'h3F
`define PSC_LAST_DIV256 8'hFF

`endif

//--- timer16_pkg.sv
// Types shared by the gated prescaled timer.
package timer16_pkg;

  typedef struct packed {
    logic run_control;
    logic idle_halt;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic ext_clock_sync;
    logic clock_source_select;
  } ctrl_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [15:0] count;
    logic [15:0] period_value;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] presc;
    logic sync1;
    logic sync2;
    logic src_prev;
    logic gate_prev;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
  } state_t;

endpackage : timer16_pkg

//--- ext_pin_model.sv
// Far-side model of the external count pin: a held level or a burst of rising edges.
module ext_pin_model (
  input wire logic core_clk,
  input wire logic level,
  input wire logic start,
  input wire logic [7:0] n_edges,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] left;
  initial left = 10'h000;
  // Each edge is high two cycles and low two, so the synchroniser cannot miss one.
  always @(posedge core_clk) begin
    if (start) begin
      left <= {n_edges, 2'b00};
    end else if (left != 10'h000) begin
      left <= left - 10'h001;
    end
  end
  assign pin = (left != 10'h000) ? left[1] : level;
endmodule : ext_pin_model

//--- tb.sv
// Self-checking bench for the gated prescaled timer over AHB-Lite.
`include "timer16_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, pin;
  logic [31:0] hrdata;
  logic idle_mode = 1'b0;
  logic level = 1'b0;
  logic start = 1'b0;
  logic [7:0] n_edges = 8'h00;
  logic [31:0] r;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int divs[4] = '{1, 8, 64, 256};

  always #25 core_clk = ~core_clk;

  gated_prescaled_timer16 dut (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .external_count_input(pin),
    .idle_mode(idle_mode), .irq(irq));
  ext_pin_model far (.core_clk(core_clk), .level(level), .start(start), .n_edges(n_edges),
    .pin(pin));

  task automatic complete_run;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // A hang anywhere in a bus wait ends here instead of running forever.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic measure(input logic [31:0] ctl, input int n, output logic [31:0] c);
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_TIMER_CONTROL, ctl);
    repeat (n) @(posedge core_clk);
    wr(`OFS_TIMER_CONTROL, 32'h0);
    bus(`OFS_COUNT, 1'b0, 32'h0, c);
  endtask : measure

  task automatic in_range(input string name, input logic [31:0] c, input int lo, input int hi);
    chk(name, {31'h0, (c >= lo && c <= hi)}, 32'h1);
  endtask : in_range

  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    bus(`OFS_TIMER_CONTROL, 1'b0, 32'h0, r);
    chk("control reset", r, 32'h0);
    chk("bus response", {31'h0, hresp}, 32'h0);
    bus(`OFS_PERIOD_VALUE, 1'b0, 32'h0, r);
    chk("period reset", r, {16'h0, `PERIOD_RESET});
    bus(8'h20, 1'b0, 32'h0, r);
    chk("unmapped read", r, 32'h0);
    wr(`OFS_TIMER_CONTROL, 32'hFFFFFFFF);
    bus(`OFS_TIMER_CONTROL, 1'b0, 32'h0, r);
    chk("control bits", r, `CTRL_IMPL_MASK);
    for (int i = 0; i < 4; i++) begin
      measure(32'h8000 | (i << 4), 1024, r);
      in_range("prescale count", r, 1024 / divs[i], 1032 / divs[i] + 1);
    end
    idle_mode <= 1'b1;
    measure(32'hA000, 100, r);
    chk("idle halted", r, 32'h0);
    measure(32'h8000, 100, r);
    in_range("idle running", r, 100, 103);
    idle_mode <= 1'b0;
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_TIMER_CONTROL, 32'h8030);
    repeat (200) @(posedge core_clk);
    wr(`OFS_TIMER_CONTROL, 32'h8030);
    repeat (200) @(posedge core_clk);
    wr(`OFS_TIMER_CONTROL, 32'h0);
    bus(`OFS_COUNT, 1'b0, 32'h0, r);
    chk("prescaler cleared", r, 32'h0);
    wr(`OFS_PERIOD_VALUE, 32'h3);
    wr(`OFS_IRQ_MASK, 32'h1);
    measure(32'h8000, 20, r);
    in_range("count wraps", r, 0, 3);
    bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, r);
    chk("match flag", r, 32'h1);
    chk("irq match", {31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    @(posedge core_clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h3);
    wr(`OFS_IRQ_STATUS, 32'h1);
    bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, r);
    chk("flag cleared", r, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(`OFS_PERIOD_VALUE, 32'hFFFF);
    wr(`OFS_COUNT, 32'h0);
    wr(`OFS_TIMER_CONTROL, 32'h8040);
    repeat (20) @(posedge core_clk);
    level <= 1'b1;
    repeat (10) @(posedge core_clk);
    level <= 1'b0;
    repeat (5) @(posedge core_clk);
    wr(`OFS_TIMER_CONTROL, 32'h0);
    bus(`OFS_COUNT, 1'b0, 32'h0, r);
    in_range("gated count", r, 9, 11);
    bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, r);
    chk("gate fall flag", r, 32'h2);
    chk("irq gate", {31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h3);
    for (int s = 0; s < 2; s++) begin
      wr(`OFS_COUNT, 32'h0);
      wr(`OFS_TIMER_CONTROL, 32'h8042 | (s << 2));
      start <= 1'b1;
      n_edges <= 8'h05;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (40) @(posedge core_clk);
      wr(`OFS_TIMER_CONTROL, 32'h0);
      bus(`OFS_COUNT, 1'b0, 32'h0, r);
      chk("external edges", r, 32'h5);
      bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, r);
      chk("gate ignored", r, 32'h0);
    end
    complete_run();
  end
endmodule : tb
